// ===== hdl/fpcl_loader.sv
`timescale 1ns/1ps
`include "fpcl_consts.svh"

module fpcl_loader #(
	parameter int INIT_OSC_CYC = `FPCL_CD2UM_MIN_CYC,
	parameter int LOAD_BYTES = `FPCL_LOAD_BYTES
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic load_clock,
	input wire logic reconfig_request_n,
	input wire logic chip_select_in_n,
	input wire logic [7:0] load_data,
	input wire logic error_status_n_i,
	output logic error_status_n_o,
	output logic error_status_n_oe,
	input wire logic load_complete_i,
	output logic load_complete_o,
	output logic load_complete_oe,
	output logic chain_enable_out_n,
	input wire logic user_startup_clock,
	input wire logic user_clock_select,
	input wire logic dual_purpose_user,
	output logic [7:0] cfg_byte,
	output logic cfg_byte_valid,
	output logic user_mode,
	output logic data_pins_user
);
	import fpcl_pkg::*;

	fpcl_core_t c_q;
	fpcl_core_t c_d;
	fpcl_link_t l_q;
	fpcl_link_t l_d;
	fpcl_sync_t s_in;
	fpcl_sync_t s;
	logic usr_edge;

	// Every pin the core reads and both link-domain flags, done and err, reach the core through here.
	always_comb begin
		s_in.request_n = reconfig_request_n;
		s_in.status_n = error_status_n_i;
		s_in.done = load_complete_i;
		s_in.link_done = l_q.done;
		s_in.link_err = l_q.err;
		s_in.usr_clk = user_startup_clock;
		s_in.usr_sel = user_clock_select;
		s_in.dp_user = dual_purpose_user;
	end

	fpcl_sync u_sync (
		.clk(ref_clk),
		.rst(rst),
		.din(s_in),
		.dout(s)
	);

	// The start-up clock is sampled, so it must run well below ref_clk/2.
	assign usr_edge = s.usr_clk & ~c_q.usr_prev;

	// Core sequencer: reset, load, halt, start-up and user mode.
	always_comb begin
		c_d = c_q;
		c_d.usr_prev = s.usr_clk;
		c_d.cnt = 16'(c_q.cnt + 16'h0001);
		case (c_q.st)
			ST_POR: begin
				// Straps are caught while the power-on delay runs.
				c_d.st_drive = 1'b1;
				c_d.clr = 1'b1;
				c_d.use_usr = s.usr_sel;
				c_d.dp_user = s.dp_user;
				if (c_q.cnt == 16'(`FPCL_POR_CYC - 1)) begin
					c_d.st = ST_RESET;
					c_d.cnt = '0;
				end
			end
			ST_RESET: begin
				c_d.st_drive = 1'b1;
				c_d.clr = 1'b1;
				c_d.seen_hi = 1'b0;
				c_d.own_err = 1'b0;
				// Release counts only once the request is back high.
				if (c_q.cnt == 16'(`FPCL_ST_LOW_CYC - 1)) begin
					c_d.st = ST_LOAD;
					c_d.st_drive = 1'b0;
					c_d.cnt = '0;
				end
			end
			ST_LOAD: begin
				// Link logic stays cleared while the shared line is low.
				c_d.clr = ~s.status_n;
				if (s.status_n) begin
					c_d.seen_hi = 1'b1;
				end
				if (s.link_err) begin
					c_d.st = ST_HALT;
					c_d.own_err = 1'b1;
					c_d.st_drive = 1'b1;
				end else if (c_q.seen_hi && !s.status_n) begin
					c_d.st = ST_HALT;
				end else if (s.done && s.link_done) begin
					// Wired done high means every device has finished.
					c_d.st = ST_CD2CU;
					c_d.cnt = '0;
				end
			end
			ST_CD2CU: begin
				if (c_q.cnt == 16'(`FPCL_CD2CU_CYC - 1)) begin
					c_d.st = ST_INIT;
					c_d.cnt = '0;
				end
			end
			ST_INIT: begin
				if (c_q.use_usr) begin
					c_d.cnt = usr_edge ? 16'(c_q.cnt + 16'h0001) : c_q.cnt;
					if (usr_edge && c_q.cnt == 16'(`FPCL_USR_INIT_CYC - 1)) begin
						c_d.st = ST_USER;
						c_d.user_mode = 1'b1;
					end
				end else if (c_q.cnt == 16'(INIT_OSC_CYC - 1)) begin
					c_d.st = ST_USER;
					c_d.user_mode = 1'b1;
				end
			end
			ST_HALT: begin
				// Only the device that found the error holds the line low.
				c_d.clr = 1'b1;
				c_d.st_drive = c_q.own_err;
			end
			ST_USER: begin
				c_d.user_mode = 1'b1;
			end
			default: begin
				c_d.st = ST_RESET;
				c_d.cnt = '0;
			end
		endcase
		// A low status line during start-up halts the chain as well.
		if ((c_q.st == ST_CD2CU || c_q.st == ST_INIT) && !s.status_n) begin
			c_d.st = ST_HALT;
		end
		// A request low restarts from any state past power-on.
		if (c_q.st != ST_POR && !s.request_n) begin
			c_d.st = ST_RESET;
			c_d.cnt = '0;
			c_d.st_drive = 1'b1;
			c_d.clr = 1'b1;
			c_d.user_mode = 1'b0;
		end
	end

	// Core state register.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			c_q <= '{st: ST_POR, cnt: 16'h0000, st_drive: 1'b1,
				clr: 1'b1, default: 1'b0};
		end else begin
			c_q <= c_d;
		end
	end

	// Byte capture on the load clock; the frame stops when done rises.
	always_comb begin
		l_d = l_q;
		l_d.byte_vld = 1'b0;
		// Identical-data chains all see chip select low together.
		if (!chip_select_in_n && !l_q.done && !l_q.err) begin
			l_d.byte_q = load_data;
			l_d.byte_vld = 1'b1;
			l_d.nbytes = 24'(l_q.nbytes + 24'h000001);
			if (l_q.nbytes == 24'h000000 && load_data != `FPCL_HDR_BYTE) begin
				l_d.err = 1'b1;
			end
			if (l_q.nbytes == 24'(LOAD_BYTES - 2)) begin
				l_d.done = 1'b1;
			end
		end
	end

	// The core clear acts without the load clock, since that clock may
	// stand still; the host leaves microseconds before the first edge,
	// so the release never meets an active edge.
	always_ff @(posedge load_clock or posedge c_q.clr) begin
		if (c_q.clr) begin
			l_q <= '0;
		end else begin
			l_q <= l_d;
		end
	end

	// Open-drain pins: the lines are only ever pulled low.
	assign error_status_n_o = 1'b0;
	assign error_status_n_oe = c_q.st_drive;
	assign load_complete_o = 1'b0;
	assign load_complete_oe = ~l_q.done;
	assign chain_enable_out_n = ~l_q.done;
	assign cfg_byte = l_q.byte_q;
	assign cfg_byte_valid = l_q.byte_vld;
	assign user_mode = c_q.user_mode;
	assign data_pins_user = c_q.user_mode & c_q.dp_user;

	// Helper counters that only the checks below read.
	logic [15:0] rel_cnt_q;
	logic [15:0] um_cnt_q;
	logic [15:0] usr_edges_q;
	localparam int REL_MAX = `FPCL_CF2ST1_CYC;
	localparam int UM_MIN = `FPCL_CD2UM_MIN_CYC;
	localparam int UM_MAX = `FPCL_CD2UM_MAX_CYC;
	localparam int USR_CYC = `FPCL_USR_INIT_CYC;
	localparam int CF2ST0 = `FPCL_CF2ST0_CYC;

	// Time since request high, time since done, and start-up clock edges.
	always_ff @(posedge ref_clk) begin
		if (rst || !s.request_n || c_q.st != ST_RESET) begin
			rel_cnt_q <= '0;
		end else begin
			rel_cnt_q <= 16'(rel_cnt_q + 16'h0001);
		end
		if (rst || c_q.st == ST_LOAD || c_q.st == ST_RESET) begin
			um_cnt_q <= '0;
			usr_edges_q <= '0;
		end else begin
			if (c_q.st != ST_USER) begin
				um_cnt_q <= 16'(um_cnt_q + 16'h0001);
			end
			if (c_q.st == ST_INIT && usr_edge) begin
				usr_edges_q <= 16'(usr_edges_q + 16'h0001);
			end
		end
	end

	// A held request reaches the status and done pins well inside 500 ns.
	chk_req_status_low: assert property (@(posedge ref_clk)
		disable iff (rst)
		(c_q.st != ST_POR && !s.request_n) |-> ##1 error_status_n_oe
			##1 load_complete_oe && chain_enable_out_n)
		else $error("status or done not low after request");

	// The same bound counted from the pin's third low cycle in user mode.
	chk_req_pin_bound: assert property (@(posedge ref_clk)
		disable iff (rst)
		(c_q.st == ST_USER && !reconfig_request_n)[*3]
			|-> ##[0:CF2ST0] error_status_n_oe)
		else $error("status not pulled low in time");

	// Power-on keeps the status line low for the first cycles.
	chk_por_hold: assert property (@(posedge ref_clk)
		disable iff (rst)
		$fell(rst) |-> error_status_n_oe [*8])
		else $error("status line not held low at power-on");

	// Status is released before 230 us elapse from request high.
	chk_release_time: assert property (@(posedge ref_clk)
		disable iff (rst)
		rel_cnt_q <= 16'(REL_MAX))
		else $error("status release later than allowed");

	// Start-up begins only with the wired done line high.
	chk_init_together: assert property (@(posedge ref_clk)
		disable iff (rst)
		$rose(c_q.st == ST_CD2CU) |-> $past(s.done) && $past(s.link_done))
		else $error("start-up began with done line low");

	// User clock counting waits out the four-period gap.
	chk_cd2cu_gap: assert property (@(posedge ref_clk)
		disable iff (rst)
		$rose(c_q.st == ST_CD2CU) |-> (c_q.st == ST_CD2CU) [*2])
		else $error("user clock enabled too soon after done");

	// Internal oscillator start-up lands in the documented window.
	chk_osc_window: assert property (@(posedge ref_clk)
		disable iff (rst)
		($rose(user_mode) && !c_q.use_usr) |->
			(um_cnt_q >= 16'(UM_MIN) && um_cnt_q <= 16'(UM_MAX)))
		else $error("user mode outside start-up window");

	// User clock start-up takes exactly the fixed edge count.
	chk_usr_edges: assert property (@(posedge ref_clk)
		disable iff (rst)
		($rose(user_mode) && c_q.use_usr) |-> usr_edges_q == 16'(USR_CYC))
		else $error("wrong start-up clock cycle count");

	// An own error pulls the shared line low on the next edge.
	chk_err_pull: assert property (@(posedge ref_clk)
		disable iff (rst)
		(c_q.st == ST_LOAD && s.link_err && s.request_n)
			|=> error_status_n_oe && c_q.st == ST_HALT)
		else $error("detected error did not pull status low");

	// A low shared line keeps the link logic cleared.
	chk_ignore_low: assert property (@(posedge ref_clk)
		disable iff (rst)
		(c_q.st == ST_LOAD && !s.status_n && s.request_n) |=> c_q.clr)
		else $error("bytes accepted while status low");

	// Done and chain enable move together, one byte early.
	chk_ceo_done: assert property (@(posedge load_clock)
		disable iff (c_q.clr)
		$rose(l_q.done) |-> !chain_enable_out_n
			&& $past(l_q.nbytes) == 24'(LOAD_BYTES - 2))
		else $error("chain enable or done count wrong");

	// A selected device captures each byte on the next rising edge.
	chk_capture: assert property (@(posedge load_clock)
		disable iff (c_q.clr)
		(!chip_select_in_n && !l_q.done && !l_q.err)
			|=> cfg_byte_valid && cfg_byte == $past(load_data))
		else $error("byte not captured");

	// Main scenarios.
	cov_user_osc: cover property (@(posedge ref_clk) disable iff (rst)
		$rose(user_mode) && !c_q.use_usr);
	cov_user_clk: cover property (@(posedge ref_clk) disable iff (rst)
		$rose(user_mode) && c_q.use_usr);
	cov_own_err: cover property (@(posedge ref_clk) disable iff (rst)
		$rose(c_q.own_err));
	cov_chain_pass: cover property (@(posedge load_clock)
		$fell(chain_enable_out_n));

endmodule // fpcl_loader

// ===== hdl/fpcl_consts.svh
`ifndef FPCL_CONSTS_SVH
`define FPCL_CONSTS_SVH

// Core clock rate in MHz; every cycle count below except the start-up clock count is derived from it.
`define FPCL_CLK_MHZ 25

// Request low to status and done low, longest time in ns.
`define FPCL_CF2ST0_NS 500
`define FPCL_CF2ST0_CYC ((`FPCL_CF2ST0_NS * `FPCL_CLK_MHZ) / 1000)

// Status low pulse that the device itself produces, least time in us.
`define FPCL_ST_LOW_US 45
`define FPCL_ST_LOW_CYC (`FPCL_ST_LOW_US * `FPCL_CLK_MHZ)

// Request high to status released, longest time in us.
`define FPCL_CF2ST1_US 230
`define FPCL_CF2ST1_CYC (`FPCL_CF2ST1_US * `FPCL_CLK_MHZ)

// Power-on reset delay in us; the length is a plain default.
`define FPCL_POR_US 100
`define FPCL_POR_CYC (`FPCL_POR_US * `FPCL_CLK_MHZ)

// Done high to user mode on the internal oscillator, in us.
`define FPCL_CD2UM_MIN_US 300
`define FPCL_CD2UM_MAX_US 650
`define FPCL_CD2UM_MIN_CYC (`FPCL_CD2UM_MIN_US * `FPCL_CLK_MHZ)
`define FPCL_CD2UM_MAX_CYC (`FPCL_CD2UM_MAX_US * `FPCL_CLK_MHZ)

// Done high to user start-up clock enabled: four longest load periods.
`define FPCL_LOAD_PER_MAX_NS 15
`define FPCL_CD2CU_PERIODS 4
`define FPCL_CD2CU_NS (`FPCL_CD2CU_PERIODS * `FPCL_LOAD_PER_MAX_NS)
`define FPCL_CD2CU_CYC ((`FPCL_CD2CU_NS * `FPCL_CLK_MHZ + 999) / 1000)

// Start-up clock cycles spent initialising with the user clock option.
`define FPCL_USR_INIT_CYC 3192

// First byte of every stream; the value is arbitrary.
`define FPCL_HDR_BYTE 8'h6A

// Default stream length in bytes; the value is arbitrary.
`define FPCL_LOAD_BYTES 1024

`endif

// ===== hdl/fpcl_pkg.sv
package fpcl_pkg;

	// Core sequencing states.
	typedef enum logic [2:0] {
		ST_POR, ST_RESET, ST_LOAD, ST_HALT, ST_CD2CU, ST_INIT, ST_USER
	} fpcl_state_t;

	// Pin and cross-domain levels that pass the two-flop synchroniser.
	typedef struct packed {
		logic request_n;
		logic status_n;
		logic done;
		logic link_done;
		logic link_err;
		logic usr_clk;
		logic usr_sel;
		logic dp_user;
	} fpcl_sync_t;

	// Whole state of the core domain.
	typedef struct packed {
		fpcl_state_t st;
		logic [15:0] cnt;
		logic st_drive;
		logic clr;
		logic seen_hi;
		logic own_err;
		logic use_usr;
		logic dp_user;
		logic usr_prev;
		logic user_mode;
	} fpcl_core_t;

	// Whole state of the load-clock domain.
	typedef struct packed {
		logic [23:0] nbytes;
		logic done;
		logic err;
		logic [7:0] byte_q;
		logic byte_vld;
	} fpcl_link_t;

endpackage

// ===== hdl/fpcl_sync.sv
`timescale 1ns/1ps

// Two-flop synchroniser; only the second stage is visible outside.
module fpcl_sync (
	input wire logic clk,
	input wire logic rst,
	input fpcl_pkg::fpcl_sync_t din,
	output fpcl_pkg::fpcl_sync_t dout
);
	import fpcl_pkg::*;

	fpcl_sync_t meta_q;

	// Both stages clear together so no stale level leaks out of reset.
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_q <= '0;
			dout <= '0;
		end else begin
			meta_q <= din;
			dout <= meta_q;
		end
	end

endmodule // fpcl_sync

// ===== tb/fpcl_host.sv
`timescale 1ns/1ps

// Host side of the byte-wide load port; the load clock idles low.
module fpcl_host (
	output logic load_clock,
	output logic cs_n,
	output logic [7:0] data,
	input wire logic status_n
);
	// Idle levels before the first frame.
	initial begin
		load_clock = 1'b0;
		cs_n = 1'b1;
		data = 8'h00;
	end

	// Sends n bytes, header first, then two falling edges to start init.
	// With obey clear the host keeps sending into a low status line.
	task automatic send(input int n, input logic [7:0] hdr, input bit obey);
		#7 cs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			if (obey && !status_n) break;
			data = (i == 0) ? hdr : 8'h10 + i[7:0];
			#15 load_clock = 1'b1;
			#15 load_clock = 1'b0;
		end
		repeat (2) begin
			#15 load_clock = 1'b1;
			#15 load_clock = 1'b0;
		end
		// Released data shows the inverse so a stale byte cannot match.
		data = ~data;
		cs_n = 1'b1;
	endtask
endmodule // fpcl_host

// ===== tb/fpcl_loader_test.sv
`timescale 1ns/1ps

module fpcl_loader_test;
	localparam int LB = 8;
	// Start-up clock period counted in core clock cycles.
	localparam int UP = 4;
	logic usr_clk, usr_sel, dp_sel;
	logic ref_clk, rst, req_n, ext_pull, hold_done;
	logic lclk, cs_n, st_oe, st_o, cd_oe, cd_o, ceo_n, cfg_vld;
	logic user_mode, dp_user;
	logic [7:0] ldata, cfg_byte;
	wire logic status_n;
	wire logic done_ln;
	int n_errors, n_checks, n_caps, ceo_at, w;

	// Both shared lines have pull-ups; any party may pull them low.
	assign status_n = ~((st_oe & ~st_o) | ext_pull);
	assign done_ln = ~((cd_oe & ~cd_o) | hold_done);

	fpcl_loader #(.LOAD_BYTES(LB)) fpcl_loader_i (
		.ref_clk(ref_clk), .rst(rst), .load_clock(lclk),
		.reconfig_request_n(req_n), .chip_select_in_n(cs_n),
		.load_data(ldata), .error_status_n_i(status_n),
		.error_status_n_o(st_o), .error_status_n_oe(st_oe),
		.load_complete_i(done_ln), .load_complete_o(cd_o),
		.load_complete_oe(cd_oe), .chain_enable_out_n(ceo_n),
		.user_startup_clock(usr_clk), .user_clock_select(usr_sel),
		.dual_purpose_user(dp_sel), .cfg_byte(cfg_byte),
		.cfg_byte_valid(cfg_vld), .user_mode(user_mode),
		.data_pins_user(dp_user)
	);

	// One host drives the clock and data lines that all devices share.
	fpcl_host fpcl_host_i (.load_clock(lclk), .cs_n(cs_n), .data(ldata),
		.status_n(status_n));

	// Core clock, 40 ns period.
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	// Start-up clock, 160 ns period, slow enough for the core to sample.
	initial begin
		usr_clk = 1'b0;
		forever #80 usr_clk = ~usr_clk;
	end

	// Counts captures on falling edges, when the valid pulse has settled.
	always @(negedge lclk) begin
		if (cfg_vld === 1'b1) n_caps++;
		if (ceo_n === 1'b0 && ceo_at == 0) ceo_at = n_caps;
	end

	task automatic end_sim;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			$display("wrong value %s expected %0h seen %0h", nm, e, g);
			n_errors++;
		end
	endtask

	// Waits for the status line (sel 0) or user mode (sel 1) to go high.
	task automatic wt(input int sel, input int lim);
		logic v;
		w = 0;
		v = 1'b0;
		while (v !== 1'b1) begin
			@(posedge ref_clk);
			#1 v = (sel == 0) ? status_n : user_mode;
			w++;
			if (w > lim) begin
				$display("wrong value wait %0d expected 1 seen 0", sel);
				n_errors++;
				end_sim();
			end
		end
	endtask

	task automatic t_power_up;
		repeat (100) @(posedge ref_clk);
		#1 chk("status", 0, status_n);
		chk("done", 0, done_ln);
		chk("od_levels", 0, {st_o, cd_o});
		wt(0, 5000);
		chk("por_len", 1, w >= 2400);
		repeat (50) @(posedge ref_clk);
	endtask

	// Good load with the shared done line held low by a slower device.
	task automatic t_load;
		n_caps = 0;
		ceo_at = 0;
		@(posedge ref_clk) hold_done <= 1'b1;
		fpcl_host_i.send(LB - 1, 8'h6A, 1'b1);
		#1 chk("caps", LB - 1, n_caps);
		chk("ceo_at", LB - 1, ceo_at);
		chk("byte", 8'h10 + LB - 2, cfg_byte);
		chk("done_oe", 0, cd_oe);
		repeat (200) @(posedge ref_clk);
		#1 chk("early", 0, user_mode);
		@(posedge ref_clk) hold_done <= 1'b0;
		wt(1, 20000);
		chk("init", 1, w >= 7500 && w <= 16250);
		chk("pins", 1, dp_user);
	endtask

	task automatic t_reconfig;
		@(posedge ref_clk) req_n <= 1'b0;
		repeat (12) @(posedge ref_clk);
		#1 chk("st_oe", 1, st_oe);
		chk("cd_oe", 1, cd_oe);
		chk("user", 0, user_mode);
		@(posedge ref_clk) req_n <= 1'b1;
		repeat (5750) @(posedge ref_clk);
		#1 chk("release", 1, status_n);
		repeat (50) @(posedge ref_clk);
	endtask

	task automatic t_bad_header;
		n_caps = 0;
		fpcl_host_i.send(LB - 1, 8'h55, 1'b1);
		repeat (10) @(posedge ref_clk);
		#1 chk("err_oe", 1, st_oe);
		chk("line", 0, status_n);
		chk("refused", 1, n_caps < 2);
		chk("ceo", 1, ceo_n);
	endtask

	// Another device holds status low; the bytes must all be ignored.
	task automatic t_ext_status;
		@(posedge ref_clk) ext_pull <= 1'b1;
		repeat (10) @(posedge ref_clk);
		n_caps = 0;
		fpcl_host_i.send(LB - 1, 8'h6A, 1'b0);
		#1 chk("caps", 0, n_caps);
		chk("cd_oe", 1, cd_oe);
		@(posedge ref_clk) ext_pull <= 1'b0;
		repeat (200) @(posedge ref_clk);
		#1 chk("halt", 1, cd_oe);
	endtask

	// Second power-up with the start-up clock strap on, pins kept as I/O.
	task automatic t_usr_clock;
		@(posedge ref_clk) rst <= 1'b1;
		usr_sel <= 1'b1;
		dp_sel <= 1'b0;
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		t_power_up();
		@(posedge ref_clk) hold_done <= 1'b1;
		fpcl_host_i.send(LB - 1, 8'h6A, 1'b1);
		repeat (10) @(posedge ref_clk);
		#1 chk("usr_ceo", 0, ceo_n);
		@(posedge ref_clk) hold_done <= 1'b0;
		wt(1, 20000);
		chk("usr_min", 1, w >= 3192 * UP);
		chk("usr_max", 1, w <= 3192 * UP + 20);
		chk("usr_pins", 0, dp_user);
	endtask

	// Main sequence.
	initial begin
		rst = 1'b1;
		req_n = 1'b1;
		ext_pull = 1'b0;
		hold_done = 1'b0;
		usr_sel = 1'b0;
		dp_sel = 1'b1;
		n_errors = 0;
		n_checks = 0;
		n_caps = 0;
		ceo_at = 0;
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		t_power_up();
		t_load();
		t_reconfig();
		t_bad_header();
		t_reconfig();
		t_ext_status();
		t_reconfig();
		t_load();
		t_usr_clock();
		end_sim();
	end
endmodule // fpcl_loader_test
